/* File: rcs_top.sv */
/*
 * Reset-cause recorder, watchdog service decode and debug forced reset.
 * Assumes RST_N is the power-on reset, all inputs are synchronous to
 * REF_CLK, and reset requests are pulses or levels seen while running.
 */
`timescale 1ns/1ps
module rcs_top
   import rcs_pkg::*;
#(
   parameter int unsigned WDOG_TIMEOUT_CYC = WDOG_TIMEOUT_DEFAULT
) (
   // Clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        RST_N,
   input  wire logic        CE,
   // Processor bus
   input  wire logic        CPU_WR,
   input  wire logic        CPU_RD,
   input  wire logic [15:0] CPU_ADDR,
   input  wire logic [7:0]  CPU_WDATA,
   output      logic [7:0]  CPU_RDATA,
   // Background debug access
   input  wire logic        DBG_WR,
   input  wire logic        DBG_RD,
   input  wire logic [15:0] DBG_ADDR,
   input  wire logic [7:0]  DBG_WDATA,
   output      logic [7:0]  DBG_RDATA,
   // Reset sources
   input  wire logic        PIN_RESET_N,
   input  wire logic        LOW_VOLTAGE,
   input  wire logic        LOW_VOLTAGE_DETECT_ENABLE,
   input  wire logic        LOW_VOLTAGE_RESET_ENABLE,
   input  wire logic        ILLEGAL_OPCODE,
   input  wire logic        STOP_EXEC,
   input  wire logic        BACKGROUND_INSTRUCTION_EXEC,
   input  wire logic        ILLEGAL_ADDRESS,
   // Options
   input  wire logic        WATCHDOG_ENABLE,
   input  wire logic        STOP_ALLOW,
   input  wire logic        BACKGROUND_MODE_ALLOW,
   // Status and reset out
   output      logic [7:0]  RESET_CAUSE,
   output      logic        SYS_RESET_N
);

   rcs_state_t              state;
   rcs_state_t              next_state;
   logic [HOLD_CNT_W-1:0]   hold_cnt;
   logic [HOLD_CNT_W-1:0]   next_hold_cnt;
   logic                    lv_kind;
   logic                    next_lv_kind;
   logic [7:0]              next_cause;
   logic [7:0]              cause_val;
   logic [7:0]              next_cpu_rdata;
   logic [7:0]              next_dbg_rdata;
   logic                    running;
   logic                    cpu_status_wr;
   logic                    cpu_status_rd;
   logic                    dbg_status_rd;
   logic                    force_req;
   logic                    lv_trip;
   logic                    pin_req;
   logic                    illegal_opcode_flag_req;
   logic                    wdog_trip;
   logic                    any_req;
   logic                    hold_done;
   logic                    lv_hold;
   logic [WDOG_CNT_W-1:0]   wdog_count;
   logic                    wdog_armed;

   // -----------------------------------------------------------------
   // Register access decode
   // -----------------------------------------------------------------
   assign running       = state == ST_RUN;
   assign cpu_status_wr = CPU_WR && CPU_ADDR == STATUS_ADDR;
   assign cpu_status_rd = CPU_RD && CPU_ADDR == STATUS_ADDR;
   assign dbg_status_rd = DBG_RD && DBG_ADDR == STATUS_ADDR;
   // Processor writes to the forced-reset address never reach this term
   assign force_req = DBG_WR && DBG_ADDR == FORCE_ADDR
                      && DBG_WDATA[FORCE_BIT];                     // R12 R14
   // Forced-reset reads fall through to zero like unmapped addresses
   assign next_cpu_rdata = cpu_status_rd ? RESET_CAUSE : READ_ZERO; // R13
   assign next_dbg_rdata = dbg_status_rd ? RESET_CAUSE : READ_ZERO; // R13

   // -----------------------------------------------------------------
   // Reset sources
   // -----------------------------------------------------------------
   assign lv_trip  = LOW_VOLTAGE && LOW_VOLTAGE_DETECT_ENABLE
                     && LOW_VOLTAGE_RESET_ENABLE;                   // R06
   assign pin_req  = !PIN_RESET_N;                                  // R08
   assign illegal_opcode_flag_req = ILLEGAL_OPCODE || (STOP_EXEC && !STOP_ALLOW)
                     || (BACKGROUND_INSTRUCTION_EXEC && !BACKGROUND_MODE_ALLOW);      // R10
   assign any_req  = lv_trip || force_req || pin_req || illegal_opcode_flag_req
                     || wdog_trip || ILLEGAL_ADDRESS;

   rcs_wdog #(
      .TIMEOUT (WDOG_CNT_W'(WDOG_TIMEOUT_CYC))
   ) u_wdog (
      .clk   (REF_CLK),
      .rst_n (RST_N),
      .ce    (CE),
      .run   (running && WATCHDOG_ENABLE),                          // R09
      .wr    (cpu_status_wr),                                       // R03 R04
      .wdata (CPU_WDATA),
      .trip  (wdog_trip),
      .count (wdog_count),
      .armed (wdog_armed)
   );

   // -----------------------------------------------------------------
   // Cause capture at reset entry
   // -----------------------------------------------------------------
   always_comb begin
      cause_val = 8'h00;                                            // R02
      if (lv_trip) begin
         cause_val[POR_BIT] = RESET_CAUSE[POR_BIT];                 // R06
         cause_val[LV_BIT]  = 1'b1;
      end else if (!force_req) begin
         cause_val[PIN_BIT]  = pin_req;                             // R07 R08
         cause_val[WDOG_BIT] = wdog_trip;                           // R09
         cause_val[ILLEGAL_OPCODE_FLAG_BIT] = illegal_opcode_flag_req;                            // R10
         cause_val[ILLEGAL_ADDRESS_FLAG_BIT] = ILLEGAL_ADDRESS;                     // R11
      end
   end

   // -----------------------------------------------------------------
   // Reset sequencer
   // -----------------------------------------------------------------
   assign hold_done = hold_cnt == '0;
   assign lv_hold   = lv_kind && LOW_VOLTAGE && LOW_VOLTAGE_DETECT_ENABLE;

   always_comb begin
      next_state    = state;
      next_hold_cnt = hold_cnt;
      next_lv_kind  = lv_kind;
      next_cause    = RESET_CAUSE;                                  // R01
      case (state)
         ST_RUN: begin
            if (any_req) begin
               next_state    = ST_ASSERT;
               next_hold_cnt = HOLD_CNT_W'(RESET_HOLD_CYC - 1);
               next_lv_kind  = lv_trip;
               next_cause    = cause_val;                           // R01
            end
         end
         ST_ASSERT: begin
            if (!hold_done) begin
               next_hold_cnt = hold_cnt - 1'b1;
            end else if (lv_hold) begin
               next_state = ST_LVHOLD;                              // R15
            end else if (PIN_RESET_N) begin
               next_state = ST_RUN;
            end
         end
         ST_LVHOLD: begin
            if (!lv_hold) begin
               next_state = ST_ASSERT;                              // R15
            end
         end
         default: begin
            next_state = ST_ASSERT;
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state       <= ST_ASSERT;
         hold_cnt    <= HOLD_CNT_W'(RESET_HOLD_CYC - 1);
         lv_kind     <= 1'b1;
         RESET_CAUSE <= STATUS_POR_VAL;                             // R05
         SYS_RESET_N <= 1'b0;
      end else if (CE) begin
         state       <= next_state;
         hold_cnt    <= next_hold_cnt;
         lv_kind     <= next_lv_kind;
         RESET_CAUSE <= next_cause;
         SYS_RESET_N <= next_state == ST_RUN;                       // R14
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         CPU_RDATA <= READ_ZERO;
         DBG_RDATA <= READ_ZERO;
      end else if (CE) begin
         CPU_RDATA <= next_cpu_rdata;
         DBG_RDATA <= next_dbg_rdata;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   a_por_flags: assert property ($rose(RST_N) |-> // R05
      RESET_CAUSE == STATUS_POR_VAL && !SYS_RESET_N)
      else $error("power-on flags wrong");
   a_status_hold: assert property (!running |=> // R01
      RESET_CAUSE == $past(RESET_CAUSE))
      else $error("status changed outside reset entry");
   a_force_clear: assert property ( // R02
      CE && running && force_req && !lv_trip |=>
      RESET_CAUSE == 8'h00 && !SYS_RESET_N)
      else $error("forced reset left a cause flag");
   a_bad_write: assert property ( // R03
      CE && running && WATCHDOG_ENABLE && cpu_status_wr
      && CPU_WDATA != SERVICE_FIRST && CPU_WDATA != SERVICE_SECOND
      && !lv_trip && !force_req |=>
      !SYS_RESET_N && RESET_CAUSE[WDOG_BIT])
      else $error("bad watchdog write did not reset");
   a_lv_flag: assert property ( // R06
      CE && running && lv_trip |=> RESET_CAUSE[LV_BIT]
      && RESET_CAUSE[POR_BIT] == $past(RESET_CAUSE[POR_BIT]))
      else $error("low-voltage flags wrong");
   a_other_clear: assert property ( // R07
      CE && running && any_req && !lv_trip |=>
      !RESET_CAUSE[POR_BIT] && !RESET_CAUSE[LV_BIT])
      else $error("power flags kept on other reset");
   a_pin_flag: assert property ( // R08
      CE && running && pin_req && !lv_trip && !force_req |=>
      RESET_CAUSE[PIN_BIT] ##1 !SYS_RESET_N)
      else $error("pin reset not recorded");
   a_illegal_opcode_flag_flag: assert property ( // R10
      CE && running && STOP_EXEC && !STOP_ALLOW && !lv_trip && !force_req
      |=> RESET_CAUSE[ILLEGAL_OPCODE_FLAG_BIT])
      else $error("barred stop not recorded");
   a_illegal_address_flag_flag: assert property ( // R11
      CE && running && ILLEGAL_ADDRESS && !lv_trip && !force_req |=>
      RESET_CAUSE[ILLEGAL_ADDRESS_FLAG_BIT])
      else $error("illegal address not recorded");
   a_no_cause_run: assert property ( // R12
      CE && running && !any_req |=> SYS_RESET_N)
      else $error("reset without a cause");
   a_force_read: assert property ( // R13
      CE && CPU_RD && CPU_ADDR == FORCE_ADDR |=> CPU_RDATA == READ_ZERO)
      else $error("forced-reset register read not zero");
   a_lv_hold: assert property ( // R15
      state == ST_LVHOLD && lv_hold |=> !SYS_RESET_N [*2])
      else $error("released while supply low");
   a_reset_len: assert property ( // R14
      CE && running && force_req |=> !SYS_RESET_N [*2])
      else $error("forced reset too short");

   c_forced: cover property (CE && running && force_req);
   c_serviced: cover property (CE && running && wdog_armed && cpu_status_wr
      && CPU_WDATA == SERVICE_SECOND);
   c_lv_hold: cover property (state == ST_LVHOLD);
   c_wdog_timeout: cover property (CE && running && wdog_trip
      && !cpu_status_wr);

endmodule

/* File: rcs_pkg.sv */
/*
 * Constants and types for the reset-cause recorder and debug forced reset.
 * Assumes a 125 MHz bus clock and a 16-bit address space shared by the
 * processor bus and the serial background debug access port.
 */
// Contract
// R01: A read-only status register tells which source caused the last reset.
// R02: A reset forced by the debug host leaves every cause flag cleared; here a low-voltage trip in the same cycle still sets bit 1 and keeps bit 7.
// R03: With the watchdog on, a status write other than 0x55 or 0xaa resets; here only processor writes do, debug host status writes are ignored.
// R04: Writing 0x55 then 0xaa services the watchdog and keeps the flags.
// R05: Power-on sets the power-on flag (bit 7) and low-voltage flag (bit 1).
// R06: An enabled low-voltage trip resets, sets bit 1 and keeps bit 7.
// R07: Other resets clear bits 7 and 1 and record each active source; here a debug forced reset in the same cycle records no source.
// R08: A low level on the external reset pin sets bit 6.
// R09: A watchdog timeout sets bit 5; no watchdog reset while it is off.
// R10: An illegal opcode, or stop or background when barred, sets bit 4.
// R11: An access to an unimplemented address sets bit 3.
// R12: The forced-reset register takes writes from the debug host only.
// R13: Reads of the forced-reset register always return zero.
// R14: A debug write of one to bit 0 of the forced-reset register resets.
// R15: With the detector on, supply resets hold until the supply recovers.
// R16: A 0xaa write not directly after a 0x55 write does not service.

package rcs_pkg;

   // -----------------------------------------------------------------
   // Register addresses
   // -----------------------------------------------------------------
   localparam logic [15:0] STATUS_ADDR = 16'h1800;
   localparam logic [15:0] FORCE_ADDR  = 16'h1801;

   // -----------------------------------------------------------------
   // Status fields and values
   // -----------------------------------------------------------------
   localparam int POR_BIT  = 7;
   localparam int PIN_BIT  = 6;
   localparam int WDOG_BIT = 5;
   localparam int ILLEGAL_OPCODE_FLAG_BIT = 4;
   localparam int ILLEGAL_ADDRESS_FLAG_BIT = 3;
   localparam int LV_BIT   = 1;
   localparam int FORCE_BIT = 0;
   localparam logic [7:0] STATUS_POR_VAL = 8'h82;
   localparam logic [7:0] READ_ZERO      = 8'h00;

   // -----------------------------------------------------------------
   // Watchdog service values and counter
   // -----------------------------------------------------------------
   localparam logic [7:0] SERVICE_FIRST  = 8'h55;
   localparam logic [7:0] SERVICE_SECOND = 8'haa;
   localparam int WDOG_CNT_W = 24;
   localparam int WDOG_TIMEOUT_DEFAULT = 262144;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 8;
   localparam int RESET_HOLD_NS  = 128;
   localparam int RESET_HOLD_CYC =
      (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CNT_W = 8;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_ASSERT,
      ST_LVHOLD
   } rcs_state_t;

endpackage

/* File: rcs_wdog.sv */
/*
 * Watchdog counter with the two-write service sequence.
 * Assumes the caller drops run whenever the watchdog is off or the system
 * is in reset, which clears the count and the sequence.
 */
`timescale 1ns/1ps
module rcs_wdog
   import rcs_pkg::*;
#(
   parameter logic [WDOG_CNT_W-1:0] TIMEOUT = WDOG_CNT_W'(WDOG_TIMEOUT_DEFAULT)
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  ce,
   // Control
   input  wire logic                  run,
   input  wire logic                  wr,
   input  wire logic [7:0]            wdata,
   // Result
   output      logic                  trip,
   output      logic [WDOG_CNT_W-1:0] count,
   output      logic                  armed
);

   logic                  is_first;
   logic                  is_second;
   logic                  bad_write;
   logic                  expired;
   logic                  serviced;
   logic [WDOG_CNT_W-1:0] next_count;
   logic                  next_armed;

   // -----------------------------------------------------------------
   // Decode
   // -----------------------------------------------------------------
   assign is_first  = wdata == SERVICE_FIRST;
   assign is_second = wdata == SERVICE_SECOND;
   assign bad_write = wr && !is_first && !is_second;               // R03
   assign expired   = count == TIMEOUT - 1'b1;
   assign trip      = run && (bad_write || expired);               // R09
   assign serviced  = wr && is_second && armed;                    // R04 R16
   assign next_count = !run ? '0 :
                       serviced ? '0 : count + 1'b1;               // R04
   assign next_armed = run && wr ? is_first : (run && armed);      // R16

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
         armed <= 1'b0;
      end else if (ce) begin
         count <= next_count;
         armed <= next_armed;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_service_clears: assert property ( // R04
      @(posedge clk) disable iff (!rst_n)
      ce && run && wr && is_second && armed |=> count == '0)
      else $error("watchdog count not cleared by service");
   a_lone_second: assert property ( // R16
      @(posedge clk) disable iff (!rst_n)
      ce && run && wr && is_second && !armed |=> count == $past(count) + 1'b1)
      else $error("lone second write serviced the watchdog");
   a_wdog_off: assert property ( // R09
      @(posedge clk) disable iff (!rst_n)
      ce && !run |=> count == '0 && !armed)
      else $error("watchdog kept counting while stopped");

endmodule

/* File: rcs_bus_agent.sv */
/*
 * Byte bus agent for one access port: single-cycle reads and writes.
 * Assumes it is called from the bench and changes lines after rising edges.
 */
`timescale 1ns/1ps
module rcs_bus_agent (
   // Clock
   input  wire logic        clk,
   // Bus
   input  wire logic [7:0]  rdata,
   output      logic        wr,
   output      logic        rd,
   output      logic [15:0] addr,
   output      logic [7:0]  wdata
);
   initial begin
      wr = 1'b0;
      rd = 1'b0;
      addr = 16'h0000;
      wdata = 8'h00;
   end

   // Processor or debug host: one-cycle write strobe with address and data
   task automatic put(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask

   task automatic get(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
      #1 d = rdata;
   endtask
endmodule

/* File: reset_cause_and_debug_force_reset_tb_top.sv */
/*
 * Self-checking bench for the reset-cause recorder and forced reset.
 * Assumes rcs_pkg, rcs_top and rcs_bus_agent are compiled first.
 */
`timescale 1ns/1ps
module reset_cause_and_debug_force_reset_tb_top
   import rcs_pkg::*;
;
   localparam int TO = 64;
   logic        clk, rst_n, pin_n, lv, lv_det, lv_rst, wd_en;
   logic        illegal_opcode_flag, illegal_address_flag, stop_x, background_instruction_x, stop_ok, bgm_ok;
   logic        c_wr, c_rd, d_wr, d_rd, sys_rst_n;
   logic [15:0] c_addr, d_addr;
   logic [7:0]  c_wd, d_wd, c_q, d_q, cause, v, cur;
   logic [4:0]  s;
   int          err_count, total_checks, n, run_cyc;

   rcs_top #(.WDOG_TIMEOUT_CYC(TO)) DUT (
      .REF_CLK(clk), .RST_N(rst_n), .CE(1'b1),
      .CPU_WR(c_wr), .CPU_RD(c_rd), .CPU_ADDR(c_addr), .CPU_WDATA(c_wd),
      .CPU_RDATA(c_q), .DBG_WR(d_wr), .DBG_RD(d_rd), .DBG_ADDR(d_addr),
      .DBG_WDATA(d_wd), .DBG_RDATA(d_q), .PIN_RESET_N(pin_n),
      .LOW_VOLTAGE(lv), .LOW_VOLTAGE_DETECT_ENABLE(lv_det),
      .LOW_VOLTAGE_RESET_ENABLE(lv_rst), .ILLEGAL_OPCODE(illegal_opcode_flag),
      .STOP_EXEC(stop_x), .BACKGROUND_INSTRUCTION_EXEC(background_instruction_x), .ILLEGAL_ADDRESS(illegal_address_flag),
      .WATCHDOG_ENABLE(wd_en), .STOP_ALLOW(stop_ok),
      .BACKGROUND_MODE_ALLOW(bgm_ok), .RESET_CAUSE(cause),
      .SYS_RESET_N(sys_rst_n)
   );
   rcs_bus_agent cpu (.clk(clk), .rdata(c_q), .wr(c_wr), .rd(c_rd),
      .addr(c_addr), .wdata(c_wd));
   rcs_bus_agent host (.clk(clk), .rdata(d_q), .wr(d_wr), .rd(d_rd),
      .addr(d_addr), .wdata(d_wd));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Cycles since the system last left reset
   always @(posedge clk) begin
      run_cyc <= sys_rst_n ? run_cyc + 1 : 0;
   end

   // ---------------------------------------------------------------
   // Checks and helpers
   // ---------------------------------------------------------------
   task automatic chk8(input string nm, input logic [7:0] e, g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk1(input string nm, input logic e, g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic end_of_test();
      $display("Checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   function automatic logic [7:0] exp_cause(input logic p, o, a, w);
      exp_cause = 8'h00;
      exp_cause[PIN_BIT] = p;
      exp_cause[ILLEGAL_OPCODE_FLAG_BIT] = o;
      exp_cause[ILLEGAL_ADDRESS_FLAG_BIT] = a;
      exp_cause[WDOG_BIT] = w;
   endfunction

   // Waits for release; optionally checks the hold length
   task automatic wait_run(input logic cnt);
      n = 0;
      while (sys_rst_n !== 1'b1 && n < 300) begin
         @(posedge clk);
         #1 n++;
      end
      if (n >= 300) begin
         err_count++;
         end_of_test();
      end
      if (cnt)
         chk8("hold_cycles", 8'(RESET_HOLD_CYC), 8'(n));
   endtask

   task automatic post(input logic [7:0] e, input logic r);
      chk1("sys_reset_n", r, sys_rst_n);
      chk8("reset_cause", e, cause);
      cur = e;
      if (!r) begin
         wait_run(1'b1);
         cpu.get(STATUS_ADDR, v);
         chk8("status_read", e, v);
      end
   endtask

   // Source vector: pin, opcode, address, stop, background
   task automatic fire(input logic [4:0] sv, input logic [7:0] e,
                       input logic r);
      @(posedge clk);
      pin_n <= ~sv[4];
      illegal_opcode_flag <= sv[3];
      illegal_address_flag <= sv[2];
      stop_x <= sv[1];
      background_instruction_x <= sv[0];
      @(posedge clk);
      pin_n <= 1'b1;
      {illegal_opcode_flag, illegal_address_flag, stop_x, background_instruction_x} <= 4'h0;
      #1 post(e, r);
   endtask

   task automatic lv_trip(input logic [7:0] e);
      @(posedge clk);
      lv <= 1'b1;
      @(posedge clk);
      #1 chk8("reset_cause", e, cause);
      repeat (30) @(posedge clk);
      #1 chk1("sys_reset_n", 1'b0, sys_rst_n);
      @(posedge clk);
      lv <= 1'b0;
      #1 wait_run(1'b0);
      cpu.get(STATUS_ADDR, v);
      chk8("status_read", e, v);
      cur = e;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {rst_n, illegal_opcode_flag, illegal_address_flag, stop_x, background_instruction_x, wd_en} = '0;
      {pin_n, lv, lv_det, lv_rst, stop_ok, bgm_ok} = '1;
      err_count = 0;
      total_checks = 0;
      cur = STATUS_POR_VAL;
      void'($urandom(3142));
      repeat (16) @(posedge clk);
      chk8("reset_cause", STATUS_POR_VAL, cause);
      rst_n <= 1'b1;
      repeat (30) @(posedge clk);
      #1 chk1("sys_reset_n", 1'b0, sys_rst_n);
      @(posedge clk) lv <= 1'b0;
      #1 wait_run(1'b0);
      cpu.get(STATUS_ADDR, v);
      chk8("status_read", STATUS_POR_VAL, v);
      lv_trip(STATUS_POR_VAL);
      fire(5'b00010, cur, 1'b1);
      fire(5'b00001, cur, 1'b1);
      @(posedge clk) {stop_ok, bgm_ok} <= 2'b00;
      fire(5'b00010, exp_cause(0, 1, 0, 0), 1'b0);
      fire(5'b00001, exp_cause(0, 1, 0, 0), 1'b0);
      fire(5'b00100, exp_cause(0, 0, 1, 0), 1'b0);
      fire(5'b10000, exp_cause(1, 0, 0, 0), 1'b0);
      lv_trip(8'h02);
      repeat (8) begin
         s = 5'($urandom_range(31, 1));
         fire(s, exp_cause(s[4], s[3] | s[1] | s[0], s[2], 0), 1'b0);
      end
      host.put(FORCE_ADDR, 8'hfe);
      #1 post(cur, 1'b1);
      host.get(FORCE_ADDR, v);
      chk8("force_read", READ_ZERO, v);
      host.get(STATUS_ADDR, v);
      chk8("status_read", cur, v);
      cpu.put(FORCE_ADDR, 8'hff);
      #1 post(cur, 1'b1);
      cpu.get(FORCE_ADDR, v);
      chk8("force_read", READ_ZERO, v);
      cpu.get(16'h2000 ^ 16'($urandom_range(255)), v);
      chk8("unmapped_read", 8'h00, v);
      host.put(FORCE_ADDR, 8'h01);
      #1 post(8'h00, 1'b0);
      @(posedge clk) lv_rst <= 1'b0;
      @(posedge clk) lv <= 1'b1;
      @(posedge clk) lv <= 1'b0;
      #1 post(cur, 1'b1);
      @(posedge clk) lv_rst <= 1'b1;
      do v = 8'($urandom); while (v == SERVICE_FIRST || v == SERVICE_SECOND);
      cpu.put(STATUS_ADDR, v);
      repeat (TO + 16) @(posedge clk);
      #1 post(cur, 1'b1);
      @(posedge clk) wd_en <= 1'b1;
      host.put(STATUS_ADDR, v);
      #1 post(cur, 1'b1);
      repeat (3) begin
         repeat (40) @(posedge clk);
         cpu.put(STATUS_ADDR, SERVICE_FIRST);
         cpu.put(16'h2000, v);
         cpu.put(STATUS_ADDR, SERVICE_SECOND);
      end
      #1 post(cur, 1'b1);
      cpu.put(STATUS_ADDR, v);
      #1 post(exp_cause(0, 0, 0, 1), 1'b0);
      fire(5'b00100, exp_cause(0, 0, 1, 0), 1'b0);
      fire(5'b10000, exp_cause(1, 0, 0, 0), 1'b0);
      cpu.put(STATUS_ADDR, SERVICE_SECOND);
      #1 post(cur, 1'b1);
      repeat (TO - 16) @(posedge clk);
      #1 chk1("sys_reset_n", 1'b1, sys_rst_n);
      n = 0;
      while (sys_rst_n === 1'b1 && n < 40) begin
         @(posedge clk);
         #1 n++;
      end
      chk8("wdog_cycles", 8'(TO), 8'(run_cyc));
      post(exp_cause(0, 0, 0, 1), 1'b0);
      end_of_test();
   end
endmodule
